// file: pkg/mcsm_pkg.sv
// Constants, register map and carrier types of the config/sleep mask block.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package mcsm_pkg;

  localparam int unsigned AW     = 12;
  localparam int unsigned GPI_N  = 8;
  localparam int unsigned TACH_N = 4;
  localparam int unsigned EV_W   = 13;

  // Register indices; byte address is four times the index
  localparam logic [AW-1:0] IDX_CFG    = 12'h0e3;
  localparam logic [AW-1:0] IDX_SLEEP  = 12'h0e4;
  localparam logic [AW-1:0] IDX_S1GPI  = 12'h0e5;
  localparam logic [AW-1:0] IDX_S1TACH = 12'h0e6;

  localparam logic [AW-1:0] ADR_CFG    = {IDX_CFG[AW-3:0], 2'h0};
  localparam logic [AW-1:0] ADR_SLEEP  = {IDX_SLEEP[AW-3:0], 2'h0};
  localparam logic [AW-1:0] ADR_S1GPI  = {IDX_S1GPI[AW-3:0], 2'h0};
  localparam logic [AW-1:0] ADR_S1TACH = {IDX_S1TACH[AW-3:0], 2'h0};
  localparam logic [AW-1:0] ADR_ERRSTS = 12'h3a0;
  localparam logic [AW-1:0] ADR_IRQMSK = 12'h3a4;

  // Values after reset
  localparam logic [7:0]        RST_CFG    = 8'h00;
  localparam logic [1:0]        RST_SLEEP  = 2'h3;
  localparam logic [7:0]        RST_S1GPI  = 8'hff;
  localparam logic [3:0]        RST_S1TACH = 4'hf;
  localparam logic [EV_W-1:0]   RST_IRQMSK = 13'h0000;

  // Sleep state codes
  localparam logic [1:0] SLP_S0  = 2'h0;
  localparam logic [1:0] SLP_S1  = 2'h1;
  localparam logic [1:0] SLP_S3  = 2'h2;
  localparam logic [1:0] SLP_S45 = 2'h3;

  // Global configuration layout, bit 7 down to bit 0
  typedef struct packed {
    logic ready;
    logic rsvd;
    logic compEn;
    logic linkEn;
    logic alertEn;
    logic gmask;
    logic lock;
    logic run;
  } mcsm_cfg_t;

  // Error event vector: gpi in 7:0, tach in 11:8, thermal in 12
  typedef struct packed {
    logic              therm;
    logic [TACH_N-1:0] tach;
    logic [GPI_N-1:0]  gpi;
  } mcsm_ev_t;

endpackage : mcsm_pkg

// file: rtl/mcsm_sticky.sv
// Sticky status bits, set by events, cleared by write-one.
// Assumes set and clear are one-cycle pulses on mclk.
module mcsm_sticky #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule : mcsm_sticky

// file: rtl/mcsm_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent slow level.
module mcsm_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      dout     <= INIT;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule : mcsm_sync

// file: rtl/mcsm_top.sv
// Global configuration, sleep-state masking and alert/interrupt logic.
// Assumes APB master on mclk; error events from same-clock monitor logic.
module mcsm_top (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [mcsm_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire mcsm_pkg::mcsm_ev_t       evRaw,
  input  wire logic                     dataValid,
  input  wire logic                     cpu1ThrIn,
  input  wire logic                     cpu2ThrIn,
  output logic                          cpu1ThrOut,
  output logic                          cpu1ThrOe,
  output logic                          cpu2ThrOut,
  output logic                          cpu2ThrOe,
  output logic                          alert_n,
  output logic                          irq,
  output logic                          pwmForceZero,
  output logic                          autoFanEn,
  output logic                          boostEn
);

  mcsm_pkg::mcsm_cfg_t             cfg_reg;
  logic [1:0]                      slpState_reg;
  logic [mcsm_pkg::GPI_N-1:0]      s1GpiMask_reg;
  logic [mcsm_pkg::TACH_N-1:0]     s1TachMask_reg;
  logic [mcsm_pkg::EV_W-1:0]       irqMask_reg;
  logic [mcsm_pkg::EV_W-1:0]       errStatus;
  logic [mcsm_pkg::EV_W-1:0]       errClr;
  mcsm_pkg::mcsm_ev_t              evMask;
  mcsm_pkg::mcsm_ev_t              evQual;
  logic [1:0]                      thrSync;
  logic [1:0]                      cpu1OeDly_reg;
  logic [1:0]                      cpu2OeDly_reg;
  logic                            cpu1Own;
  logic                            cpu2Own;
  logic                            globalMask;
  logic                            summary;
  logic                            setupPh;
  logic                            accessPh;
  logic                            wrEn;
  logic                            hit;
  logic [7:0]                      rdByte;
  logic [31:0]                     rdWord;

  // Bus phases
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable && pready;
  assign wrEn     = accessPh && pwrite && !pslverr;

  // Address decode and read data
  always_comb begin
    hit    = 1'b1;
    rdByte = 8'h00;
    rdWord = 32'h0000_0000;
    case (paddr)
      mcsm_pkg::ADR_CFG: begin
        rdByte = cfg_reg;
      end
      mcsm_pkg::ADR_SLEEP: begin
        rdByte = {6'h00, slpState_reg};
      end
      mcsm_pkg::ADR_S1GPI: begin
        rdByte = s1GpiMask_reg;
      end
      mcsm_pkg::ADR_S1TACH: begin
        rdByte = {4'h0, s1TachMask_reg};
      end
      mcsm_pkg::ADR_ERRSTS: begin
        rdWord[mcsm_pkg::EV_W-1:0] = errStatus;
      end
      mcsm_pkg::ADR_IRQMSK: begin
        rdWord[mcsm_pkg::EV_W-1:0] = irqMask_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    rdWord[7:0] = rdWord[7:0] | rdByte;
  end

  // No wait state: answer prepared in setup, taken in the first access cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setupPh) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= pwrite ? 32'h0000_0000 : rdWord;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // Global configuration register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_reg <= mcsm_pkg::RST_CFG;
    end else begin
      if (dataValid) begin
        cfg_reg.ready <= 1'b1;
      end
      if (wrEn && paddr == mcsm_pkg::ADR_CFG) begin
        if (!cfg_reg.lock) begin
          cfg_reg.run  <= pwdata[0];
          cfg_reg.lock <= pwdata[1];
        end
        cfg_reg.gmask   <= pwdata[2];
        cfg_reg.alertEn <= pwdata[3];
        cfg_reg.linkEn  <= pwdata[4];
        cfg_reg.compEn  <= pwdata[5];
        cfg_reg.rsvd    <= pwdata[6];
      end
    end
  end

  // Sleep state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slpState_reg <= mcsm_pkg::RST_SLEEP;
    end else if (wrEn && paddr == mcsm_pkg::ADR_SLEEP) begin
      slpState_reg <= pwdata[1:0];
    end
  end

  // S1 mask registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1GpiMask_reg  <= mcsm_pkg::RST_S1GPI;
      s1TachMask_reg <= mcsm_pkg::RST_S1TACH;
    end else if (wrEn) begin
      if (paddr == mcsm_pkg::ADR_S1GPI) begin
        s1GpiMask_reg <= pwdata[7:0];
      end
      if (paddr == mcsm_pkg::ADR_S1TACH) begin
        s1TachMask_reg <= pwdata[3:0];
      end
    end
  end

  // Interrupt mask register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqMask_reg <= mcsm_pkg::RST_IRQMSK;
    end else if (wrEn && paddr == mcsm_pkg::ADR_IRQMSK) begin
      irqMask_reg <= pwdata[mcsm_pkg::EV_W-1:0];
    end
  end

  // Event masking by mode, global mask and sleep state
  assign globalMask = !cfg_reg.run || cfg_reg.gmask;

  always_comb begin
    evMask = '0;
    case (slpState_reg)
      mcsm_pkg::SLP_S0: begin
        evMask = '0;
      end
      mcsm_pkg::SLP_S1: begin
        evMask.gpi  = s1GpiMask_reg;
        evMask.tach = s1TachMask_reg;
      end
      default: begin
        evMask = '1;
      end
    endcase
    if (globalMask) begin
      evMask = '1;
    end
  end

  assign evQual = evRaw & ~evMask;

  assign errClr = (wrEn && paddr == mcsm_pkg::ADR_ERRSTS)
                ? pwdata[mcsm_pkg::EV_W-1:0] : '0;

  mcsm_sticky #(
    .W (mcsm_pkg::EV_W)
  ) u_errSts (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (evQual),
    .clr   (errClr),
    .q     (errStatus)
  );

  assign summary = |errStatus;

  // Alert and interrupt outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alert_n <= 1'b1;
      irq     <= 1'b0;
    end else begin
      alert_n <= !(cfg_reg.alertEn &&
                   (cfg_reg.compEn ? evQual.therm
                                   : summary));
      irq     <= |(errStatus & irqMask_reg);
    end
  end

  // Fan control mode outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwmForceZero <= 1'b1;
      autoFanEn    <= 1'b0;
      boostEn      <= 1'b0;
    end else begin
      pwmForceZero <= !cfg_reg.run;
      autoFanEn    <= cfg_reg.run;
      boostEn      <= cfg_reg.run;
    end
  end

  // Throttle link, open-drain active low
  mcsm_sync #(
    .W    (2),
    .INIT (2'h3)
  ) u_thrSync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({cpu2ThrIn, cpu1ThrIn}),
    .dout  (thrSync)
  );

  // Own pull stays visible through the synchroniser for two more edges
  assign cpu1Own = cpu1ThrOe || (cpu1OeDly_reg != 2'h0);
  assign cpu2Own = cpu2ThrOe || (cpu2OeDly_reg != 2'h0);

  // A pin pulled low by us is not taken as a source, avoiding ping-pong
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpu1ThrOut    <= 1'b0;
      cpu2ThrOut    <= 1'b0;
      cpu1ThrOe     <= 1'b0;
      cpu2ThrOe     <= 1'b0;
      cpu1OeDly_reg <= 2'h0;
      cpu2OeDly_reg <= 2'h0;
    end else begin
      cpu1ThrOut    <= 1'b0;
      cpu2ThrOut    <= 1'b0;
      cpu1OeDly_reg <= {cpu1OeDly_reg[0], cpu1ThrOe};
      cpu2OeDly_reg <= {cpu2OeDly_reg[0], cpu2ThrOe};
      cpu2ThrOe     <= cfg_reg.linkEn && !thrSync[0] && !cpu1Own;
      cpu1ThrOe     <= cfg_reg.linkEn && !thrSync[1] && !cpu2Own;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_basic_mode: assert property (
    !cfg_reg.run |-> (evQual == '0) ##1 (pwmForceZero && !autoFanEn))
    else $error("basic mode not honoured");

  chk_run_mode: assert property (
    cfg_reg.run |=> (autoFanEn && boostEn && !pwmForceZero))
    else $error("run mode outputs wrong");

  chk_lock_hold: assert property (
    cfg_reg.lock |=> (cfg_reg.lock && $stable(cfg_reg.run)))
    else $error("locked bits changed");

  chk_gmask_all: assert property (
    cfg_reg.gmask |-> (evQual == '0))
    else $error("global mask leaked event");

  chk_alert_off: assert property (
    !cfg_reg.alertEn |=> alert_n)
    else $error("alert active while disabled");

  chk_comp_mode: assert property (
    (cfg_reg.alertEn && cfg_reg.compEn) |=> (alert_n == !$past(evQual.therm)))
    else $error("comparator alert wrong");

  chk_ready_set: assert property (
    dataValid |=> cfg_reg.ready [*2])
    else $error("ready not set");

  chk_sleep_rst: assert property (
    $rose(rst_n) |-> (slpState_reg == mcsm_pkg::SLP_S45))
    else $error("sleep field not S4/5 after reset");

  chk_s1_gpi: assert property (
    (slpState_reg == mcsm_pkg::SLP_S1) |->
      ((evQual.gpi & s1GpiMask_reg) == '0 && (evQual.tach & s1TachMask_reg) == '0))
    else $error("S1 mask leaked");

  chk_summ_alert: assert property (
    (cfg_reg.alertEn && !cfg_reg.compEn && summary) |=> !alert_n)
    else $error("summary did not raise alert");

  chk_masked_sts: assert property (
    ((errStatus & ~$past(errStatus) & ~$past(evQual)) == '0))
    else $error("status set by masked event");

  chk_link_drive: assert property (
    (cfg_reg.linkEn && !thrSync[0] && !cpu1Own) |=> cpu2ThrOe)
    else $error("throttle link not driven");

  chk_link_quiet: assert property (
    !cfg_reg.linkEn |=> (!cpu1ThrOe && !cpu2ThrOe))
    else $error("throttle driven while link off");

  chk_s1_therm: assert property (
    ((slpState_reg == mcsm_pkg::SLP_S1) && !globalMask) |-> (evQual.therm == evRaw.therm))
    else $error("thermal event masked in S1");

  cov_run_set: cover property ($rose(cfg_reg.run));
  cov_lock_set: cover property ($rose(cfg_reg.lock));
  cov_alert: cover property ($fell(alert_n));
  cov_link: cover property ($rose(cpu2ThrOe));
  cov_s1_mask: cover property (
    (slpState_reg == mcsm_pkg::SLP_S1) && cfg_reg.run && (evRaw.gpi != '0));

endmodule : mcsm_top

// file: verification/mcsm_pins_model.sv
// Board model of the two open-drain throttle pins with pull-ups.
// Assumes an enable high means that party pulls the pin low.
module mcsm_pins_model (
  input  wire logic cpu1Oe,
  input  wire logic cpu2Oe,
  input  wire logic cpu1Ext,
  input  wire logic cpu2Ext,
  output logic      cpu1Pin,
  output logic      cpu2Pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins not shorted on this board, so the link may be set
  assign cpu1Pin = ~(cpu1Oe | cpu1Ext);
  assign cpu2Pin = ~(cpu2Oe | cpu2Ext);
endmodule : mcsm_pins_model

// file: verification/tb_mcsm_top.sv
// Register-level bench of the config and sleep mask block.
// Assumes zero-wait-state APB slave and same-clock event inputs.
module tb_mcsm_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic               mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rdv;
  mcsm_pkg::mcsm_ev_t evRaw;
  logic               dataValid, cpu1In, cpu2In, cpu1Oe, cpu2Oe, cpu1Ext, cpu2Ext, slvErr;
  logic               cpu1Out, cpu2Out;
  logic               alert_n, irq, pwmForceZero, autoFanEn, boostEn;
  int                 fail_count, tests_run;

  mcsm_top mcsm_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evRaw(evRaw), .dataValid(dataValid), .cpu1ThrIn(cpu1In),
    .cpu2ThrIn(cpu2In), .cpu1ThrOut(cpu1Out), .cpu1ThrOe(cpu1Oe), .cpu2ThrOut(cpu2Out),
    .cpu2ThrOe(cpu2Oe), .alert_n(alert_n), .irq(irq), .pwmForceZero(pwmForceZero),
    .autoFanEn(autoFanEn), .boostEn(boostEn));
  mcsm_pins_model mcsm_pins_model_i (.cpu1Oe(cpu1Oe), .cpu2Oe(cpu2Oe), .cpu1Ext(cpu1Ext),
    .cpu2Ext(cpu2Ext), .cpu1Pin(cpu1In), .cpu2Pin(cpu2In));

  always #5 mclk = ~mclk;

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      complete_run();
    end else begin
      rdv = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd

  task automatic ev(input logic [12:0] v);
    evRaw <= v;
    @(posedge mclk);
    evRaw <= '0;
    settle(3);
  endtask : ev

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    evRaw = '0;
    dataValid = 1'b0;
    cpu1Ext = 1'b0;
    cpu2Ext = 1'b0;
    fail_count = 0;
    tests_run = 0;
    settle(4);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(mcsm_pkg::ADR_CFG, 32'h00);
    rd(mcsm_pkg::ADR_SLEEP, 32'h03);
    rd(mcsm_pkg::ADR_S1GPI, 32'hff);
    rd(mcsm_pkg::ADR_S1TACH, 32'h0f);
    rd(12'h3fc, 32'h0);
    chk(32'(slvErr), 32'h1);
    chk(32'({pwmForceZero, autoFanEn, boostEn}), 32'h4);
    wr(mcsm_pkg::ADR_SLEEP, 32'hfd);
    rd(mcsm_pkg::ADR_SLEEP, 32'h01);
    wr(mcsm_pkg::ADR_SLEEP, 32'h0);
    ev(13'h0001);
    rd(mcsm_pkg::ADR_ERRSTS, 32'h0);
    wr(mcsm_pkg::ADR_IRQMSK, 32'h1);
    wr(mcsm_pkg::ADR_CFG, 32'h09);
    settle(1);
    chk(32'({pwmForceZero, autoFanEn, boostEn}), 32'h3);
    ev(13'h0001);
    rd(mcsm_pkg::ADR_ERRSTS, 32'h1);
    chk(32'({alert_n, irq}), 32'h1);
    wr(mcsm_pkg::ADR_CFG, 32'h01);
    settle(2);
    chk(32'(alert_n), 32'h1);
    wr(mcsm_pkg::ADR_ERRSTS, 32'h1);
    settle(2);
    rd(mcsm_pkg::ADR_ERRSTS, 32'h0);
    chk(32'(irq), 32'h0);
    wr(mcsm_pkg::ADR_CFG, 32'h0d);
    ev(13'h1fff);
    rd(mcsm_pkg::ADR_ERRSTS, 32'h0);
    rd(mcsm_pkg::ADR_S1GPI, 32'hff);
    wr(mcsm_pkg::ADR_CFG, 32'h09);
    wr(mcsm_pkg::ADR_SLEEP, 32'h1);
    wr(mcsm_pkg::ADR_S1GPI, 32'hfe);
    wr(mcsm_pkg::ADR_S1TACH, 32'hfe);
    rd(mcsm_pkg::ADR_S1TACH, 32'h0e);
    ev(13'h0fff);
    rd(mcsm_pkg::ADR_ERRSTS, 32'h101);
    wr(mcsm_pkg::ADR_ERRSTS, 32'h1fff);
    for (int s = 2; s < 4; s++) begin
      wr(mcsm_pkg::ADR_SLEEP, 32'(s));
      ev(13'h1fff);
      rd(mcsm_pkg::ADR_ERRSTS, 32'h0);
    end
    wr(mcsm_pkg::ADR_SLEEP, 32'h0);
    wr(mcsm_pkg::ADR_CFG, 32'h29);
    ev(13'h0001);
    chk(32'(alert_n), 32'h1);
    wr(mcsm_pkg::ADR_ERRSTS, 32'h1fff);
    evRaw <= 13'h1000;
    settle(3);
    chk(32'(alert_n), 32'h0);
    evRaw <= '0;
    settle(3);
    chk(32'(alert_n), 32'h1);
    wr(mcsm_pkg::ADR_CFG, 32'h19);
    cpu1Ext <= 1'b1;
    settle(6);
    chk(32'({cpu2Oe, cpu1Oe, cpu2Out}), 32'h4);
    cpu1Ext <= 1'b0;
    settle(8);
    chk(32'({cpu2Oe, cpu1Oe}), 32'h0);
    cpu2Ext <= 1'b1;
    settle(6);
    chk(32'({cpu1Oe, cpu2Oe, cpu1Out}), 32'h4);
    cpu2Ext <= 1'b0;
    settle(8);
    chk(32'({cpu1Oe, cpu2Oe}), 32'h0);
    dataValid <= 1'b1;
    settle(3);
    dataValid <= 1'b0;
    wr(mcsm_pkg::ADR_CFG, 32'h19);
    rd(mcsm_pkg::ADR_CFG, 32'h99);
    wr(mcsm_pkg::ADR_CFG, 32'h03);
    wr(mcsm_pkg::ADR_CFG, 32'h00);
    rd(mcsm_pkg::ADR_CFG, 32'h83);
    cpu1Ext <= 1'b1;
    settle(6);
    chk(32'(cpu2Oe), 32'h0);
    cpu1Ext <= 1'b0;
    rst_n <= 1'b0;
    settle(4);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(mcsm_pkg::ADR_CFG, 32'h00);
    rd(mcsm_pkg::ADR_SLEEP, 32'h03);
    complete_run();
  end
endmodule : tb_mcsm_top
